// ---- src/bus_master_consts.vh ----
// Constants for the system bus master and local decode block
`ifndef BUS_MASTER_CONSTS_VH
`define BUS_MASTER_CONSTS_VH
// I/O decode: gate field on port bits 7..4, choice on bits 4..2
`define IO_GATE_D 4'hd
`define IO_GATE_E 4'he
`define IO_SEL_INTC 3'h6
`define IO_SEL_TIMER 3'h7
`define IO_SEL_PERIPH 3'h1
`define IO_SEL_PARALLEL 3'h2
`define IO_SEL_SERIAL 3'h3
// ROM region is 0000-1FFF: address bits 15..13 all zero
`define ROM_REGION_TOP 3'h0
// ROM size codes
`define ROM_SIZE_1K 2'h0
`define ROM_SIZE_2K 2'h1
`define ROM_SIZE_4K 2'h2
// Override mask bits in the set-mask accumulator
`define OVR_BIT_LO 6
`define OVR_BIT_HI 7
// Bus controller reset values (active-low outputs idle high, except priority out, which idles low)
`define BUS_REQ_N_RST 1'b1
`define BUS_PRO_N_RST 1'b0
`define BUSY_N_RST 1'b1
`define ADDRESS_DRIVER_ENABLE_N_RST 1'b1
`define CMD_N_RST 4'hf
`endif

// ---- src/system_bus_master.v ----
// System bus master controller with local I/O and ROM decode
// Operation
// RULE1: Arbitrate only on qualified command for addresses not on-board I/O or memory.
// RULE2: Controller state changes occur on falling edges of the bus clock.
// RULE3: Read command follows read strobe; write command is write strobe delayed half cycle.
// RULE4: Transfer start request drives bus request low and priority out high.
// RULE5: On priority in low, next falling edge drives busy and driver enable low; driver enable here waits until a command is latched.
// RULE6: Busy low means bus in use; owner holds until it raises busy.
// RULE7: Driver enable turns on address and data drivers; address drivers transmit; here they transmit only outside remote mode.
// RULE8: Master mode: data drivers transmit for writes, receive for reads.
// RULE9: Drive the active-low bus command matching the request input.
// RULE10: Slave acknowledge ends command, drops drivers, qualified command goes high; here qualified command stays low until the CPU strobe ends.
// RULE11: Release: bus request high and priority out low, then raise busy.
// RULE12: Set-mask bits 6 and 7 set override; ownership held across commands.
// RULE13: Five exclusive low I/O selects from D8-DB, DC-DF, E4-E7, E8-EB, EC-EF.
// RULE14: Any I/O select gives local acknowledge, ready, buffer enable with strobe.
// RULE15: Local buffer direction follows status line one: 1 toward CPU.
// RULE16: Port address bits 0 and 1 pass to selected device.
// RULE17: Unmatched I/O keeps local acknowledge high and starts a bus transfer.
// RULE18: Outside remote mode enable address buffer, and data buffer when unacknowledged.
// RULE19: Addresses 0000-1FFF are ROM only, never RAM or bus.
// RULE20: ROM socket ranges follow configured size 1K, 2K or 4K.
// RULE21: ROM range gives acknowledge and ready; with read strobe, ROM output enable.
// RULE22: Bits 0-11 go to ROMs, bits 10-15 choose the socket.
// RULE23: Names ending _n are active low, others active high.
// RULE24: After reset the controller is idle with all drivers off.
// RULE25: Priority and acknowledge inputs synchronized before use.
`timescale 1ns/1ps
`include "bus_master_consts.vh"
module system_bus_master (
  input wire clock_in,
  input wire resetn_in,
  input wire [15:0] cpu_address_in,
  input wire cpu_io_select_in,
  input wire cpu_read_strobe_n_in,
  input wire cpu_write_strobe_n_in,
  input wire cpu_status_one_in,
  input wire cpu_serial_output_in,
  input wire [1:0] rom_size_in,
  input wire remote_access_mode_in,
  input wire onboard_ram_hit_in,
  input wire bus_clock_n_in,
  input wire bus_priority_in_n_in,
  input wire bus_aack_n_in,
  input wire bus_xack_n_in,
  output reg interrupt_ctrl_select_n_out,
  output reg interval_timer_select_n_out,
  output reg peripheral_processor_select_n_out,
  output reg parallel_port_select_n_out,
  output reg serial_port_select_n_out,
  output reg [1:0] io_function_address_out,
  output reg local_io_acknowledge_n_out,
  output reg rom_acknowledge_n_out,
  output reg rom_output_enable_n_out,
  output reg rom_socket0_select_n_out,
  output reg rom_socket1_select_n_out,
  output reg [11:0] rom_address_out,
  output reg cpu_ready_out,
  output reg local_buffer_enable_out,
  output reg local_buffer_to_cpu_out,
  output reg local_address_buffer_enable_out,
  output reg system_data_buffer_enable_out,
  output reg qualified_command_n_out,
  output reg bus_request_n_out,
  output reg bus_priority_out_n_out,
  output reg busy_n_out,
  output reg busy_oe_out,
  output reg address_driver_enable_n_out,
  output reg address_driver_transmit_out,
  output reg data_driver_direction_out,
  output reg [3:0] bus_command_n_out,
  output reg [3:0] bus_command_oe_out
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins from the CPU and the bus arrive asynchronously; two flops each
  localparam SYN_W = 11;
  wire [SYN_W-1:0] syn_raw;
  reg [SYN_W-1:0] syn_a_q;
  reg [SYN_W-1:0] syn_q;
  assign syn_raw = {bus_clock_n_in, bus_priority_in_n_in, bus_aack_n_in, bus_xack_n_in,
    cpu_io_select_in, cpu_read_strobe_n_in, cpu_write_strobe_n_in, cpu_status_one_in,
    cpu_serial_output_in, remote_access_mode_in, onboard_ram_hit_in};
  reg [15:0] addr_a_q;
  reg [15:0] addr_q;
  reg [1:0] size_a_q;
  reg [1:0] size_q;

  // Two-stage capture of every asynchronous input
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      syn_a_q <= 11'h7f8;
      syn_q <= 11'h7f8;
      addr_a_q <= 16'h0000;
      addr_q <= 16'h0000;
      size_a_q <= 2'h0;
      size_q <= 2'h0;
    end else begin
      syn_a_q <= syn_raw;
      syn_q <= syn_a_q; // RULE25
      addr_a_q <= cpu_address_in;
      addr_q <= addr_a_q;
      size_a_q <= rom_size_in;
      size_q <= size_a_q;
    end
  end

  wire bclk_n_s = syn_q[10];
  wire bprn_n_s = syn_q[9];
  wire aack_n_s = syn_q[8];
  wire xack_n_s = syn_q[7];
  wire io_s = syn_q[6];
  wire rd_n_s = syn_q[5];
  wire wr_n_s = syn_q[4];
  wire s1_s = syn_q[3];
  wire bus_hold_override_s = syn_q[2];
  wire remote_s = syn_q[1];
  wire ram_hit_s = syn_q[0];

  // ****************************************************************
  // Bus clock edge finder
  // ****************************************************************
  reg bclk_prev_q;
  reg wr_half_q;
  // Falling edge of the active-low bus clock marks each controller step
  wire bclk_fall = bclk_prev_q & ~bclk_n_s; // RULE2
  wire bclk_rise = ~bclk_prev_q & bclk_n_s;

  // Edge history and half-cycle delay of the write strobe
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bclk_prev_q <= 1'b1;
      wr_half_q <= 1'b1;
    end else begin
      bclk_prev_q <= bclk_n_s;
      if (wr_n_s)
        wr_half_q <= 1'b1;
      else if (bclk_rise)
        wr_half_q <= 1'b0; // RULE3
    end
  end

  // ****************************************************************
  // Local decode
  // ****************************************************************
  reg [4:0] io_sel;
  reg rom_hit;
  reg rom_sock1;
  reg io_any;
  wire strobe = ~rd_n_s | ~wr_n_s;

  // I/O and ROM address decode
  always @* begin
    io_sel = 5'h00;
    if (io_s && (addr_q[7:4] == `IO_GATE_D || addr_q[7:4] == `IO_GATE_E)) begin
      case (addr_q[4:2]) // RULE13
        `IO_SEL_INTC: io_sel = (addr_q[7:4] == `IO_GATE_D) ? 5'h01 : 5'h00;
        `IO_SEL_TIMER: io_sel = (addr_q[7:4] == `IO_GATE_D) ? 5'h02 : 5'h00;
        `IO_SEL_PERIPH: io_sel = (addr_q[7:4] == `IO_GATE_E) ? 5'h04 : 5'h00;
        `IO_SEL_PARALLEL: io_sel = (addr_q[7:4] == `IO_GATE_E) ? 5'h08 : 5'h00;
        `IO_SEL_SERIAL: io_sel = (addr_q[7:4] == `IO_GATE_E) ? 5'h10 : 5'h00;
        default: io_sel = 5'h00;
      endcase
    end
    io_any = |io_sel;
    // Socket chosen from upper bits by fitted size
    rom_hit = 1'b0;
    rom_sock1 = 1'b0;
    if (!io_s && addr_q[15:13] == `ROM_REGION_TOP) begin // RULE19
      case (size_q) // RULE20 RULE22
        `ROM_SIZE_1K: begin
          rom_hit = (addr_q[12:11] == 2'h0);
          rom_sock1 = addr_q[10];
        end
        `ROM_SIZE_2K: begin
          rom_hit = ~addr_q[12];
          rom_sock1 = addr_q[11];
        end
        default: begin
          rom_hit = 1'b1;
          rom_sock1 = addr_q[12];
        end
      endcase
    end
  end

  // Whole 0000-1FFF region is kept off the bus even where no socket answers
  wire rom_region = ~io_s & (addr_q[15:13] == `ROM_REGION_TOP);
  wire offboard = io_s ? ~io_any : ~(rom_region | ram_hit_s); // RULE17
  wire qualified_command = ~rd_n_s | ~wr_half_q; // RULE3

  // ****************************************************************
  // Bus controller state machine
  // ****************************************************************
  localparam ST_IDLE = 4'h1;
  localparam ST_REQ = 4'h2;
  localparam ST_OWN = 4'h4;
  localparam ST_REL = 4'h8;
  reg [3:0] state_q;
  reg [3:0] cmd_q;
  reg ovr_q;
  // Set once a command is acknowledged, cleared when the CPU strobe ends
  reg cmd_done_q;

  // Only a bus clock falling edge advances the controller
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE; // RULE24
      cmd_q <= 4'h0;
      ovr_q <= 1'b0;
      cmd_done_q <= 1'b0;
    end else if (bclk_fall) begin
      ovr_q <= bus_hold_override_s; // RULE12
      // A strobe that outlasts its acknowledge must not issue a second command
      if (!qualified_command)
        cmd_done_q <= 1'b0;
      case (state_q)
        ST_IDLE: if (qualified_command && offboard) state_q <= ST_REQ; // RULE1
        ST_REQ: if (!bprn_n_s) state_q <= ST_OWN; // RULE5
        ST_OWN: begin
          // Request lines {io rd, io wr, mem rd, mem wr}
          if (qualified_command && cmd_q == 4'h0 && !cmd_done_q)
            cmd_q <= {io_s & ~rd_n_s, io_s & ~wr_half_q,
              ~io_s & ~rd_n_s, ~io_s & ~wr_half_q}; // RULE9
          else if (cmd_q != 4'h0 && (!aack_n_s || !xack_n_s)) begin
            cmd_q <= 4'h0; // RULE10
            cmd_done_q <= 1'b1;
          end else if (cmd_q == 4'h0 && !qualified_command && !ovr_q)
            state_q <= ST_REL; // RULE11
        end
        ST_REL: state_q <= ST_IDLE; // RULE6
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // All outputs are flopped so the pins never glitch on decode hazards
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      {interrupt_ctrl_select_n_out, interval_timer_select_n_out} <= 2'h3;
      {peripheral_processor_select_n_out, parallel_port_select_n_out} <= 2'h3;
      serial_port_select_n_out <= 1'b1;
      io_function_address_out <= 2'h0;
      local_io_acknowledge_n_out <= 1'b1;
      rom_acknowledge_n_out <= 1'b1;
      rom_output_enable_n_out <= 1'b1;
      rom_socket0_select_n_out <= 1'b1;
      rom_socket1_select_n_out <= 1'b1;
      rom_address_out <= 12'h000;
      cpu_ready_out <= 1'b0;
      local_buffer_enable_out <= 1'b0;
      local_buffer_to_cpu_out <= 1'b0;
      local_address_buffer_enable_out <= 1'b0;
      system_data_buffer_enable_out <= 1'b0;
      qualified_command_n_out <= 1'b1;
      bus_request_n_out <= `BUS_REQ_N_RST;
      bus_priority_out_n_out <= `BUS_PRO_N_RST;
      busy_n_out <= `BUSY_N_RST;
      busy_oe_out <= 1'b0;
      address_driver_enable_n_out <= `ADDRESS_DRIVER_ENABLE_N_RST;
      address_driver_transmit_out <= 1'b0;
      data_driver_direction_out <= 1'b0;
      bus_command_n_out <= `CMD_N_RST;
      bus_command_oe_out <= 4'h0;
    end else begin
      interrupt_ctrl_select_n_out <= ~io_sel[0];
      interval_timer_select_n_out <= ~io_sel[1];
      peripheral_processor_select_n_out <= ~io_sel[2];
      parallel_port_select_n_out <= ~io_sel[3];
      serial_port_select_n_out <= ~io_sel[4];
      io_function_address_out <= addr_q[1:0]; // RULE16
      local_io_acknowledge_n_out <= ~io_any;
      rom_acknowledge_n_out <= ~rom_hit;
      rom_output_enable_n_out <= ~(rom_hit & ~rd_n_s); // RULE21
      rom_socket0_select_n_out <= ~(rom_hit & ~rom_sock1);
      rom_socket1_select_n_out <= ~(rom_hit & rom_sock1);
      rom_address_out <= addr_q[11:0]; // RULE22
      cpu_ready_out <= io_any | rom_hit; // RULE14 RULE21
      local_buffer_enable_out <= (io_any & strobe) | (rom_hit & ~rd_n_s); // RULE14
      local_buffer_to_cpu_out <= s1_s; // RULE15
      local_address_buffer_enable_out <= ~remote_s; // RULE18
      system_data_buffer_enable_out <= ~remote_s & ~io_any & offboard; // RULE18
      qualified_command_n_out <= ~qualified_command;
      // Request held from arbitration through ownership
      bus_request_n_out <= ~(state_q == ST_REQ || state_q == ST_OWN); // RULE4 RULE11
      bus_priority_out_n_out <= (state_q == ST_REQ || state_q == ST_OWN);
      busy_n_out <= ~(state_q == ST_OWN || state_q == ST_REL); // RULE5 RULE6
      busy_oe_out <= (state_q == ST_OWN || state_q == ST_REL);
      address_driver_enable_n_out <= ~(state_q == ST_OWN && cmd_q != 4'h0); // RULE7 RULE10
      address_driver_transmit_out <= ~remote_s; // RULE7
      data_driver_direction_out <= cmd_q[2] | cmd_q[0]; // RULE8
      bus_command_n_out <= ~cmd_q; // RULE9 RULE23
      bus_command_oe_out <= (state_q == ST_OWN) ? 4'hf : 4'h0;
    end
  end

endmodule

// ---- tb/bus_master_asserts.sv ----
// Port assertions for the system bus master and local decode
`timescale 1ns/1ps
module bus_master_asserts (
  input wire clock_in,
  input wire resetn_in,
  input wire local_io_acknowledge_n_out,
  input wire rom_acknowledge_n_out,
  input wire rom_output_enable_n_out,
  input wire cpu_ready_out,
  input wire bus_request_n_out,
  input wire bus_priority_out_n_out,
  input wire busy_n_out,
  input wire address_driver_enable_n_out,
  input wire data_driver_direction_out,
  input wire [3:0] bus_command_n_out
);
  // ********************
  // Bus ownership and local decode checks
  // ********************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_req_prio: assert property (bus_priority_out_n_out == !bus_request_n_out)
    else $error("request and priority out disagree");
  a_release_order: assert property ($rose(busy_n_out) |-> $past(bus_request_n_out))
    else $error("busy raised before request dropped");
  a_own_grant: assert property ($fell(busy_n_out) |-> !bus_request_n_out)
    else $error("busy taken without request");
  // A bus clock is about sixteen local clocks (125 ns over 8 ns), so ownership spans more than eight
  a_busy_hold: assert property ($fell(busy_n_out) |-> !busy_n_out [*8])
    else $error("busy released too early");
  a_cmd_owned: assert property (bus_command_n_out != 4'hf |->
    !busy_n_out && !address_driver_enable_n_out)
    else $error("command without ownership");
  a_cmd_single: assert property ($onehot0(~bus_command_n_out))
    else $error("two commands at once");
  a_write_dir: assert property (!bus_command_n_out[2] || !bus_command_n_out[0] |->
    data_driver_direction_out)
    else $error("write not transmitting");
  a_read_dir: assert property (!bus_command_n_out[3] || !bus_command_n_out[1] |->
    !data_driver_direction_out)
    else $error("read not receiving");
  a_io_ready: assert property (!local_io_acknowledge_n_out |-> cpu_ready_out)
    else $error("local ack without ready");
  a_rom_oe: assert property (!rom_output_enable_n_out |->
    !rom_acknowledge_n_out && cpu_ready_out)
    else $error("rom enable without ack");
endmodule

// ---- tb/bus_side_model.sv ----
// Far-side model: bus clock, priority grant and slave acknowledge
`timescale 1ns/1ps
module bus_side_model (
  input wire bus_request_n_in,
  input wire [3:0] bus_command_n_in,
  input wire [3:0] delay_in,
  output logic bus_clock_n_out,
  output wire priority_n_out,
  output wire aack_n_out,
  output wire xack_n_out
);
  int grant_q = 0;
  int ack_q = 0;
  // ********************
  // Backplane behaviour
  // ********************
  // Bus clock runs free on the backplane
  initial bus_clock_n_out = 1'b1;
  always #62.5 bus_clock_n_out = ~bus_clock_n_out;
  // Grant and acknowledge count falling bus clocks, so delay sets the speed
  always @(negedge bus_clock_n_out) begin
    grant_q <= bus_request_n_in ? 0 : grant_q + 1;
    ack_q <= &bus_command_n_in ? 0 : ack_q + 1;
  end
  // Pulled-up lines return high at once when the command is released
  assign priority_n_out = !(grant_q > delay_in);
  assign aack_n_out = !(!(&bus_command_n_in) && ack_q > delay_in && delay_in[0]);
  assign xack_n_out = !(!(&bus_command_n_in) && ack_q > delay_in && !delay_in[0]);
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the system bus master and local decode
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %0t got %0h want %0h", $time, (a), (e)); end end
module tb_top;
  logic clock_in = 0, resetn_in = 0, cpu_io_select_in = 0, cpu_read_strobe_n_in = 1;
  logic cpu_write_strobe_n_in = 1, cpu_status_one_in = 0, cpu_serial_output_in = 0;
  logic remote_access_mode_in = 0, onboard_ram_hit_in = 0;
  logic [15:0] cpu_address_in = 0;
  logic [1:0] rom_size_in = 0;
  logic [3:0] delay = 0;
  wire bus_clock_n_in, bus_priority_in_n_in, bus_aack_n_in, bus_xack_n_in;
  wire interrupt_ctrl_select_n_out, interval_timer_select_n_out, parallel_port_select_n_out;
  wire peripheral_processor_select_n_out, serial_port_select_n_out, local_io_acknowledge_n_out;
  wire rom_acknowledge_n_out, rom_output_enable_n_out, rom_socket0_select_n_out;
  wire rom_socket1_select_n_out, cpu_ready_out, local_buffer_enable_out, local_buffer_to_cpu_out;
  wire local_address_buffer_enable_out, system_data_buffer_enable_out, qualified_command_n_out;
  wire bus_request_n_out, bus_priority_out_n_out, busy_n_out, busy_oe_out;
  wire address_driver_enable_n_out, address_driver_transmit_out, data_driver_direction_out;
  wire [1:0] io_function_address_out;
  wire [11:0] rom_address_out;
  wire [3:0] bus_command_n_out, bus_command_oe_out;
  int i, j, seed = 32'h249b9bd3, errors = 0, samples_checked = 0;
  system_bus_master system_bus_master_inst (.*);
  bus_side_model bus_side_model_inst (.bus_request_n_in(bus_request_n_out),
    .bus_command_n_in(bus_command_n_out), .delay_in(delay), .bus_clock_n_out(bus_clock_n_in),
    .priority_n_out(bus_priority_in_n_in), .aack_n_out(bus_aack_n_in),
    .xack_n_out(bus_xack_n_in));
  // ********************
  // Expectations and tasks
  // ********************
  always #4 clock_in = ~clock_in;
  // Low-active selects in order interrupt, timer, peripheral, parallel, serial
  function automatic logic [4:0] io_exp(input logic [7:0] a);
    io_exp = 5'h1f;
    case (a[7:2])
      6'h36: io_exp[4] = 1'b0;
      6'h37: io_exp[3] = 1'b0;
      6'h39: io_exp[2] = 1'b0;
      6'h3a: io_exp[1] = 1'b0;
      6'h3b: io_exp[0] = 1'b0;
      default: ;
    endcase
  endfunction
  // Returns ack, socket 0 and socket 1, all low active; size 3 acts as 4K
  function automatic logic [2:0] rom_exp(input logic [1:0] s, input logic [15:0] a);
    int r;
    r = 1024 << (s == 2'h3 ? 2 : s);
    rom_exp = {a >= 2 * r, a >= r, a < r || a >= 2 * r};
  endfunction
  // One off-board cycle; k is io read, io write, mem read, mem write
  task automatic bus_cycle(input int k);
    int n;
    cpu_address_in = k < 2 ? 16'h0010 : 16'h8000;
    cpu_io_select_in = k < 2;
    cpu_status_one_in = !k[0];
    cpu_serial_output_in = (k == 1);
    if (k[0]) cpu_write_strobe_n_in = 1'b0;
    else cpu_read_strobe_n_in = 1'b0;
    for (n = 0; bus_command_n_out[3 - k] !== 1'b0 && n < 2000; n++) @(negedge clock_in);
    `CHK(bus_command_n_out[3 - k], 1'b0)
    `CHK(data_driver_direction_out, k[0])
    `CHK({address_driver_enable_n_out, address_driver_transmit_out}, 2'h1)
    `CHK({qualified_command_n_out, system_data_buffer_enable_out, busy_oe_out,
      bus_command_oe_out}, 7'h3f)
    `CHK(local_io_acknowledge_n_out, 1'b1)
    for (n = 0; bus_command_n_out !== 4'hf && n < 2000; n++) @(negedge clock_in);
    cpu_read_strobe_n_in = 1'b1;
    cpu_write_strobe_n_in = 1'b1;
    repeat (80) @(negedge clock_in);
    `CHK(busy_n_out, k != 1)
  endtask
  task end_of_test;
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Watchdog well beyond the few tens of microseconds the sequence needs
  initial begin
    #400000;
    errors++;
    end_of_test;
  end
  // Main sequence, inputs change on the falling clock edge
  initial begin
    repeat (8) @(negedge clock_in);
    resetn_in = 1'b1;
    repeat (4) @(negedge clock_in);
    `CHK({busy_n_out, bus_request_n_out, address_driver_enable_n_out, bus_command_oe_out}, 7'h70)
    cpu_io_select_in = 1'b1;
    for (i = 0; i < 48; i++) begin
      cpu_address_in = $random(seed);
      cpu_address_in[7:0] = i < 24 ? 8'hd8 + i : $random(seed);
      cpu_status_one_in = $random(seed);
      remote_access_mode_in = 1'($random(seed));
      repeat (5) @(negedge clock_in);
      `CHK({interrupt_ctrl_select_n_out, interval_timer_select_n_out,
        peripheral_processor_select_n_out, parallel_port_select_n_out,
        serial_port_select_n_out}, io_exp(cpu_address_in[7:0]))
      `CHK(local_io_acknowledge_n_out, &io_exp(cpu_address_in[7:0]))
      `CHK(io_function_address_out, cpu_address_in[1:0])
      `CHK({local_buffer_to_cpu_out, local_address_buffer_enable_out, address_driver_transmit_out,
        system_data_buffer_enable_out}, {cpu_status_one_in, {2{!remote_access_mode_in}},
        !remote_access_mode_in && &io_exp(cpu_address_in[7:0])})
    end
    cpu_io_select_in = 1'b0;
    remote_access_mode_in = 1'b0;
    for (i = 0; i < 48; i++) begin
      j = i % 8;
      rom_size_in = i < 24 ? i / 8 : $random(seed);
      cpu_address_in = i < 24 ? (16'h0400 << (j / 2)) - (j % 2 == 0) : $random(seed) & 16'h3fff;
      repeat (5) @(negedge clock_in);
      `CHK({rom_acknowledge_n_out, rom_socket0_select_n_out, rom_socket1_select_n_out},
        rom_exp(rom_size_in, cpu_address_in))
      `CHK(rom_address_out, cpu_address_in[11:0])
    end
    cpu_address_in = 16'h0005;
    cpu_read_strobe_n_in = 1'b0;
    cpu_status_one_in = 1'b1;
    repeat (5) @(negedge clock_in);
    `CHK({rom_output_enable_n_out, local_buffer_enable_out, cpu_ready_out, bus_request_n_out}, 4'h7)
    // On-board RAM hit must keep the read off the system bus
    cpu_address_in = 16'h8000;
    onboard_ram_hit_in = 1'b1;
    repeat (40) @(negedge clock_in);
    `CHK({bus_request_n_out, qualified_command_n_out, system_data_buffer_enable_out}, 3'h4)
    cpu_read_strobe_n_in = 1'b1;
    onboard_ram_hit_in = 1'b0;
    repeat (8) @(negedge clock_in);
    for (i = 0; i < 8; i++) begin
      delay = i < 4 ? 4'h0 : $random(seed);
      bus_cycle(i % 4);
    end
    end_of_test;
  end
endmodule
bind system_bus_master bus_master_asserts bus_master_asserts_inst (.clock_in, .resetn_in,
  .local_io_acknowledge_n_out, .rom_acknowledge_n_out, .rom_output_enable_n_out,
  .cpu_ready_out, .bus_request_n_out, .bus_priority_out_n_out, .busy_n_out,
  .address_driver_enable_n_out, .data_driver_direction_out, .bus_command_n_out);
